// *** status_report_irq_control.sv ***
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Behaviour
// - Overflow flag sets when the microprocessor finds the status silo full, unless a host read pops the silo in the same cycle.
// - Status silo holds 64 entries; overflow when a further entry arrives while all 64 are unread.
// - Overflow flag requests an interrupt only with its enable set.
// - Master clear clears listed control bits plus neighbour and silo-head flags.
// - Master clear flushes the received character silo and then self-clears.
// - Status flag requests an interrupt only with its enable set.
// - Status flag sets on every microprocessor entry written into the silo.
// - Host read of the status report register clears the status flag.
// - Status flag is host-writable only while flag write enable is set.
// - Reset clears overflow, both enables and the status flag.
module status_report_irq_control #(
  parameter int DEPTH = status_report_pkg::SILO_DEPTH
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Microprocessor status entries
  input wire status_report_pkg::status_entry_t status_push,
  // Side effects and interrupt
  output status_report_pkg::master_clear_t master_clear,
  output logic irq_vector_b
);
  import status_report_pkg::*;

  typedef struct packed {
    logic [15:0] ctl;
    logic [31:0] rdata;
    logic ready;
    logic err;
    master_clear_t mc;
    logic irq;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;
  logic [15:0] silo_head;
  logic [$clog2(DEPTH):0] silo_level;
  logic silo_full;
  logic silo_pop;
  logic silo_flush;

  ////////////////////////////////////////////////////////////////
  // Status silo, popped by host reads of the status report register
  status_silo #(.DEPTH(DEPTH)) u_silo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(silo_flush),
    .push(status_push),
    .pop(silo_pop),
    .head(silo_head),
    .level(silo_level),
    .full(silo_full)
  );

  logic access;
  logic rd_stat;
  logic wr_ctl;
  assign access = psel && penable && !st.ready;
  assign rd_stat = access && !pwrite && paddr == STATREP_ADDR;
  assign wr_ctl = access && pwrite && paddr == SYSCTL_ADDR;
  assign silo_pop = rd_stat;
  assign silo_flush = st.mc.clear_lcr; // Whole status silo flushed with the clear

  ////////////////////////////////////////////////////////////////
  // One wait state: ready rises the cycle after access begins
  always_comb begin
    next_st = st;
    next_st.ready = access;
    next_st.err = 1'b0;
    next_st.mc = '0;
    if (access) begin
      next_st.rdata = 32'h0000_0000;
      unique case (paddr)
        SYSCTL_ADDR: next_st.rdata = {16'h0000, st.ctl};
        STATREP_ADDR: next_st.rdata = {16'h0000, silo_head};
        SILO_LEVEL_ADDR: next_st.rdata = 32'(silo_level);
        default: next_st.err = 1'b1;
      endcase
    end
    // Host writes; flag bit only while its write enable is set
    if (wr_ctl) begin
      next_st.ctl[BIT_FLAG_WE] = pwdata[BIT_FLAG_WE];
      next_st.ctl[BIT_OVF] = pwdata[BIT_OVF];
      next_st.ctl[BIT_OVF_IE] = pwdata[BIT_OVF_IE];
      next_st.ctl[BIT_STAT_IE] = pwdata[BIT_STAT_IE];
      next_st.ctl[8:0] = pwdata[8:0];
      if (st.ctl[BIT_FLAG_WE]) begin
        next_st.ctl[BIT_STAT_FLAG] = pwdata[BIT_STAT_FLAG];
      end
      next_st.ctl[BIT_MCLR] = pwdata[BIT_MCLR];
    end
    // Read of status report register clears the flag
    if (rd_stat) begin
      next_st.ctl[BIT_STAT_FLAG] = 1'b0;
    end
    // Master clear acts one cycle after being written, then self-clears
    if (st.ctl[BIT_MCLR]) begin
      next_st.ctl = st.ctl & ~MCLR_MASK;
      next_st.ctl[BIT_STAT_FLAG] = 1'b0;
      next_st.mc = '{clear_ric: 1'b1, clear_lcr: 1'b1, flush_rx_silo: 1'b1};
    end
    // Hardware sets win over clears
    if (status_push.valid) begin
      next_st.ctl[BIT_STAT_FLAG] = 1'b1;
      if (silo_full && !silo_pop) begin
        next_st.ctl[BIT_OVF] = 1'b1;
      end
    end
    next_st.ctl[14] = 1'b0;
    next_st.irq = (next_st.ctl[BIT_OVF] && next_st.ctl[BIT_OVF_IE]) ||
      (next_st.ctl[BIT_STAT_FLAG] && next_st.ctl[BIT_STAT_IE]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ctl <= SYSCTL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign master_clear = st.mc;
  assign irq_vector_b = st.irq;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence mc_written_s;
    wr_ctl && pwdata[BIT_MCLR];
  endsequence

  mclr_self_clear_a: assert property (mc_written_s |=> ##1 !st.ctl[BIT_MCLR])
    else $error("master clear did not self clear");
  mclr_flush_a: assert property (mc_written_s |=> ##1 master_clear.flush_rx_silo)
    else $error("master clear did not flush");
  ovf_irq_gate_a: assert property (st.ctl[BIT_OVF] && !st.ctl[BIT_STAT_FLAG] |-> irq_vector_b == st.ctl[BIT_OVF_IE])
    else $error("overflow interrupt gate wrong");
  stat_irq_gate_a: assert property (st.ctl[BIT_STAT_FLAG] && !st.ctl[BIT_OVF] |-> irq_vector_b == st.ctl[BIT_STAT_IE])
    else $error("status interrupt gate wrong");
  stat_set_a: assert property (status_push.valid |=> st.ctl[BIT_STAT_FLAG])
    else $error("status flag not set by entry");
  stat_read_clr_a: assert property (rd_stat && !status_push.valid && !st.ctl[BIT_MCLR] |=> !st.ctl[BIT_STAT_FLAG])
    else $error("status flag not cleared by read");
  flag_protect_a: assert property (wr_ctl && !st.ctl[BIT_FLAG_WE] && !status_push.valid && !rd_stat
    && !st.ctl[BIT_MCLR] |=> $stable(st.ctl[BIT_STAT_FLAG]))
    else $error("status flag written while protected");
  ovf_set_a: assert property (status_push.valid && silo_full && !silo_pop |=> st.ctl[BIT_OVF])
    else $error("overflow not raised on full silo");
  bit14_zero_a: assert property (!st.ctl[14])
    else $error("unused bit reads one");

endmodule

// *** status_report_pkg.sv ***
package status_report_pkg;

  // Register byte addresses on the APB
  localparam logic [7:0] SYSCTL_ADDR = 8'h00;
  localparam logic [7:0] STATREP_ADDR = 8'h04;
  localparam logic [7:0] SILO_LEVEL_ADDR = 8'h08;

  // Field positions in the system control word
  localparam int BIT_FLAG_WE = 9;
  localparam int BIT_OVF = 10;
  localparam int BIT_MCLR = 11;
  localparam int BIT_OVF_IE = 12;
  localparam int BIT_STAT_IE = 13;
  localparam int BIT_STAT_FLAG = 15;

  // Sizes and reset values
  localparam int SILO_DEPTH = 64;
  localparam logic [15:0] SYSCTL_RESET = 16'h0000;
  // Bits 4, 5, 8 and 14 survive a master clear
  localparam logic [15:0] MCLR_MASK = 16'hbecf;

  // Entry pushed by the microprocessor into the status silo
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } status_entry_t;

  // Side effects towards the neighbouring registers
  typedef struct packed {
    logic clear_ric;
    logic clear_lcr;
    logic flush_rx_silo;
  } master_clear_t;

endpackage

// *** status_silo.sv ***
`timescale 1ns/1ps
module status_silo #(
  parameter int DEPTH = status_report_pkg::SILO_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic flush,
  input wire status_report_pkg::status_entry_t push,
  input wire logic pop,
  // Status
  output logic [15:0] head,
  output logic [$clog2(DEPTH):0] level,
  output logic full
);
  import status_report_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } silo_state_t;

  silo_state_t st;
  silo_state_t next_st;
  logic do_push;
  logic do_pop;

  ////////////////////////////////////////////////////////////////
  // Push refused when full; pop ignored when empty
  always_comb begin
    next_st = st;
    do_pop = pop && st.cnt != '0;
    do_push = push.valid && (st.cnt != (AW+1)'(DEPTH));
    if (do_push) begin
      next_st.mem[st.wr] = push.data;
      next_st.wr = st.wr + AW'(1);
    end
    if (do_pop) begin
      next_st.rd = st.rd + AW'(1);
    end
    next_st.cnt = st.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (flush) begin
      next_st.rd = '0;
      next_st.wr = '0;
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign head = st.cnt != '0 ? st.mem[st.rd] : 16'h0000;
  assign level = st.cnt;
  assign full = st.cnt == (AW+1)'(DEPTH);

endmodule

// *** status_source.sv ***
`timescale 1ns/1ps
// Stands in for the microprocessor queuing status reports
module status_source (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request from the bench
  input wire logic start,
  input wire logic [7:0] count,
  // Entries towards the block
  output status_report_pkg::status_entry_t push
);
  import status_report_pkg::*;
  logic [7:0] left;
  // One entry a cycle; data counts up so reads show the order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 8'h00;
      push <= '0;
    end else begin
      if (start) left <= count;
      else if (left != 8'h00) left <= left - 8'h01;
      push.valid <= !start && left != 8'h00;
      push.data <= 16'h0100 + {8'h00, count - left};
    end
  end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import status_report_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, irq_vector_b;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic start = 0;
  logic [7:0] count = 8'h00;
  logic err;
  status_entry_t status_push;
  master_clear_t master_clear;
  int failures = 0, cmp_count = 0, mc_pulses = 0;
  always #50 pclk = ~pclk;
  status_report_irq_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .status_push(status_push), .master_clear(master_clear), .irq_vector_b(irq_vector_b));
  status_source u_src (.pclk(pclk), .presetn(presetn), .start(start), .count(count), .push(status_push));
  // Side effect pulses must come all together
  always @(posedge pclk) if (master_clear === 3'b111) mc_pulses++;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Setup, access, then hold until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      test_done();
    end
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(q, exp);
  endtask
  // Microprocessor queues n reports back to back
  task feed(input logic [7:0] n);
    @(posedge pclk);
    start <= 1; count <= n;
    @(posedge pclk);
    start <= 0;
    repeat (n + 3) @(posedge pclk);
  endtask
  task test_done;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    #1_000_000;
    failures++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(SYSCTL_ADDR, 32'h0);
    apb(1, SYSCTL_ADDR, 32'hf000);
    rd(SYSCTL_ADDR, 32'h3000);
    feed(1);
    rd(SYSCTL_ADDR, 32'hb000);
    chk(irq_vector_b, 1);
    // Host services the status interrupt at once
    rd(STATREP_ADDR, 32'h0100);
    rd(SYSCTL_ADDR, 32'h3000);
    chk(irq_vector_b, 0);
    apb(1, SYSCTL_ADDR, 32'h1000);
    feed(65);
    rd(SILO_LEVEL_ADDR, 32'd64);
    rd(SYSCTL_ADDR, 32'h9400);
    chk(irq_vector_b, 1);
    apb(1, SYSCTL_ADDR, 32'h0400);
    chk(irq_vector_b, 0);
    rd(SYSCTL_ADDR, 32'h8400);
    apb(1, SYSCTL_ADDR, 32'h0200);
    rd(SYSCTL_ADDR, 32'h8200);
    apb(1, SYSCTL_ADDR, 32'hb231);
    rd(SYSCTL_ADDR, 32'hb231);
    apb(1, SYSCTL_ADDR, 32'h3e31);
    repeat (4) @(posedge pclk);
    rd(SYSCTL_ADDR, 32'h0030);
    chk(mc_pulses, 1);
    rd(SILO_LEVEL_ADDR, 32'd0);
    apb(0, 8'h0c, 32'h0);
    chk(err, 1);
    test_done();
  end
endmodule
